// ---- src/ssmac_pkg.sv ----
// Purpose: shared types and constants of the packed shift and multiply datapath
// Assumes: 32-bit general registers, 64-bit accumulator pairs
// Notes: one request per cycle, answer registered one cycle later
package ssmac_pkg;
  localparam int ACC_NUM = 4;
  localparam int ACC_W = 64;
  localparam int WORD_W = 32;
  // shift count widths per element size
  localparam int BYTE_CNT_W = 3;
  localparam int HALF_CNT_W = 4;
  localparam int WORD_CNT_W = 5;
  // fixed point limits
  localparam logic [15:0] Q15_MAX = 16'h7fff;
  localparam logic [15:0] Q15_NEG1 = 16'h8000;
  localparam logic [15:0] U16_MAX = 16'hffff;
  localparam logic [31:0] Q31_MAX = 32'h7fff_ffff;
  localparam logic [31:0] Q31_NEG1 = 32'h8000_0000;
  localparam logic [31:0] Q31_RND = 32'h0000_8000;
  localparam logic [63:0] Q63_MAX = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] Q63_MIN = 64'h8000_0000_0000_0000;
  localparam logic [63:0] ACC_RST = 64'h0;

  typedef enum logic [4:0] {
    OP_BYTE_LANE_LOGICAL_RIGHT_SHIFT,
    OP_HALF_LANE_ARITH_RIGHT_SHIFT,
    OP_HALF_LANE_ROUNDING_RIGHT_SHIFT,
    OP_WORD_ROUNDING_RIGHT_SHIFT,
    OP_BYTE_BY_HALF_MULTIPLY_LEFT,
    OP_BYTE_BY_HALF_MULTIPLY_RIGHT,
    OP_Q15_ROUNDING_MULTIPLY,
    OP_Q15_EXPANDING_MULTIPLY_LEFT,
    OP_Q15_EXPANDING_MULTIPLY_RIGHT,
    OP_BYTE_DOT_ACCUMULATE,
    OP_BYTE_DOT_SUBTRACT,
    OP_Q15_DOT_ACCUMULATE,
    OP_Q15_DOT_SUBTRACT,
    OP_COMPLEX_REAL_PART_ACCUMULATE,
    OP_Q31_SAT_MAC,
    OP_Q31_SAT_MSUB,
    OP_SINGLE_LANE_MAC,
    OP_SINGLE_LANE_MAC_Q31_CLAMP,
    OP_MOVE_FROM_HIGH,
    OP_MOVE_FROM_LOW,
    OP_MOVE_TO_HIGH,
    OP_MOVE_TO_LOW
  } ssmac_op_t;

  typedef struct packed {
    logic valid;
    ssmac_op_t op;
    logic [31:0] rs;
    logic [31:0] rt;
    logic [4:0] imm;
    logic use_var;
    logic left;
    logic [1:0] accumulator_select;
  } ssmac_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } ssmac_res_t;
endpackage

// ---- src/ssmac_q15_mul.sv ----
// Purpose: one Q15 by Q15 fractional product, shifted into Q31
// Assumes: purely combinational, used per halfword lane
// Notes: minus one times minus one clamps to the largest Q31 value
`timescale 1ns/1ps
`default_nettype none
module ssmac_q15_mul (
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  output logic [31:0] prod,
  output logic sat
);
  logic [31:0] full;

  // signed product, doubled, with the single overflow case clamped
  always_comb begin
    full = $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
    sat = (a == ssmac_pkg::Q15_NEG1) && (b == ssmac_pkg::Q15_NEG1);
    prod = sat ? ssmac_pkg::Q31_MAX : {full[30:0], 1'b0};
  end
endmodule
`default_nettype wire

// ---- src/ssmac_unit.sv ----
// Purpose: packed shift and multiply-accumulate execution datapath
// Assumes: decoded requests from the pipeline on the core clock
// Notes: answer and accumulator update land one cycle after the request
// What this block does
// RL1 - byte lanes shift right logically, zero fill, count from low 3 bits
// RL2 - halfword lanes shift right arithmetically, count from low 4 bits
// RL3 - rounding shifts add one at the top discarded bit first
// RL4 - full word rounding arithmetic right shift, count from low 5 bits
// RL5 - left or right byte pair times halfword pair, unsigned, no shift
// RL6 - a byte-by-halfword lane above 16 bits gives all ones
// RL7 - Q15 same-size multiply rounds half-way values upward per lane
// RL8 - Q15 same-size multiply of minus one by minus one gives Q15 maximum
// RL9 - register-only multiplies never touch accumulators one to three
// RL10 - expanding Q15 multiply gives doubled 32-bit product, clamped at minus one
// RL11 - byte dot accumulate adds sum of two byte products to accumulator
// RL12 - byte dot subtract takes sum of two byte products from accumulator
// RL13 - Q15 dot accumulate adds clamped doubled lane products, sign-extended
// RL14 - each 32-bit Q15 lane product enters the sum sign-extended to 64 bits
// RL15 - Q15 dot subtract takes both clamped lane products from accumulator
// RL16 - complex real part adds first lane product minus second lane product
// RL17 - Q31 mac forms doubled 32x32 Q63 product, clamped at minus one
// RL18 - Q31 mac clamps accumulator to its limits on overflow
// RL19 - Q31 msub subtracts the product and clamps accumulator on overflow
// RL20 - single lane mac accumulates clamped product of selected halfwords
// RL21 - clamping single lane mac limits the accumulator to Q31 range
// RL22 - four accumulator pairs, selectable, readable and writable by moves
// RL23 - zero shift count returns the element unchanged, rounding adds nothing
`timescale 1ns/1ps
`default_nettype none
module ssmac_unit #(
  parameter int ACC_NUM = ssmac_pkg::ACC_NUM
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ssmac_pkg::ssmac_req_t req,
  output var ssmac_pkg::ssmac_res_t res
);
  ssmac_pkg::ssmac_res_t res_r;
  ssmac_pkg::ssmac_res_t res_nxt;
  logic [63:0] acc_r [ACC_NUM];
  logic [63:0] acc_nxt [ACC_NUM];
  logic [4:0] cnt;
  logic gpr_op;
  logic [31:0] p_high;
  logic [31:0] p_low;
  logic sat_high;
  logic sat_low;
  logic [16:0] h_ext;
  logic [16:0] h_rnd;
  logic [32:0] w_ext;
  logic [32:0] w_rnd;
  logic [7:0] byte_a;
  logic [23:0] p24;
  logic [15:0] bp_high;
  logic [15:0] bp_low;
  logic [16:0] bdot;
  logic [63:0] q63;
  logic [63:0] full64;
  logic [63:0] lane64;
  logic [63:0] sum64;
  logic [63:0] acc_sel;
  logic [31:0] rnd_sum;
  logic [1:0] sel;

  assign res = res_r;

  // saturate a 65-bit signed sum to the accumulator range
  function automatic logic [63:0] sat64(input logic [64:0] s);
    if (s[64] != s[63]) begin
      sat64 = s[64] ? ssmac_pkg::Q63_MIN : ssmac_pkg::Q63_MAX;
    end else begin
      sat64 = s[63:0];
    end
  endfunction

  // limit a 64-bit signed value to the Q31 range, sign-extended
  function automatic logic [63:0] sat_q31(input logic [63:0] s);
    if (s[63:31] != {33{s[63]}}) begin
      sat_q31 = s[63] ? {{32{1'b1}}, ssmac_pkg::Q31_NEG1} : {32'h0, ssmac_pkg::Q31_MAX};
    end else begin
      sat_q31 = s;
    end
  endfunction

  // the two halfword lanes of fractional products
  ssmac_q15_mul u_mul_high (
    .a(req.rs[31:16]),
    .b(req.rt[31:16]),
    .prod(p_high),
    .sat(sat_high)
  );

  ssmac_q15_mul u_mul_low (
    .a(req.rs[15:0]),
    .b(req.rt[15:0]),
    .prod(p_low),
    .sat(sat_low)
  );

  // operand shaping shared by several operations
  always_comb begin
    cnt = req.use_var ? req.rs[4:0] : req.imm;
    sel = req.accumulator_select;
    acc_sel = acc_r[sel];
    // byte products pick the left or right byte pair of each source
    if (req.left) begin
      bp_high = {8'h0, req.rs[31:24]} * {8'h0, req.rt[31:24]};
      bp_low = {8'h0, req.rs[23:16]} * {8'h0, req.rt[23:16]};
    end else begin
      bp_high = {8'h0, req.rs[15:8]} * {8'h0, req.rt[15:8]};
      bp_low = {8'h0, req.rs[7:0]} * {8'h0, req.rt[7:0]};
    end
    bdot = {1'b0, bp_high} + {1'b0, bp_low};
    // doubled 32x32 product, the minus one pair clamps
    full64 = $signed({{32{req.rs[31]}}, req.rs}) * $signed({{32{req.rt[31]}}, req.rt});
    if (req.rs == ssmac_pkg::Q31_NEG1 && req.rt == ssmac_pkg::Q31_NEG1) begin
      q63 = ssmac_pkg::Q63_MAX; // RL17
    end else begin
      q63 = {full64[62:0], 1'b0}; // RL17
    end
    // selected single lane, sign-extended
    lane64 = req.left ? {{32{p_high[31]}}, p_high} : {{32{p_low[31]}}, p_low}; // RL20
    // each 32-bit lane product enters the sum sign-extended to 64 bits
    sum64 = {{32{p_high[31]}}, p_high} + {{32{p_low[31]}}, p_low}; // RL13 RL14
    gpr_op = !(req.op inside {ssmac_pkg::OP_BYTE_DOT_ACCUMULATE,
                              ssmac_pkg::OP_BYTE_DOT_SUBTRACT,
                              ssmac_pkg::OP_Q15_DOT_ACCUMULATE,
                              ssmac_pkg::OP_Q15_DOT_SUBTRACT,
                              ssmac_pkg::OP_COMPLEX_REAL_PART_ACCUMULATE,
                              ssmac_pkg::OP_Q31_SAT_MAC,
                              ssmac_pkg::OP_Q31_SAT_MSUB,
                              ssmac_pkg::OP_SINGLE_LANE_MAC,
                              ssmac_pkg::OP_SINGLE_LANE_MAC_Q31_CLAMP,
                              ssmac_pkg::OP_MOVE_TO_HIGH,
                              ssmac_pkg::OP_MOVE_TO_LOW});
  end

  // next answer and next accumulator state
  always_comb begin
    res_nxt = '0;
    res_nxt.valid = req.valid;
    acc_nxt = acc_r; // RL9
    h_ext = '0;
    h_rnd = '0;
    w_ext = '0;
    w_rnd = '0;
    byte_a = '0;
    p24 = '0;
    rnd_sum = '0;
    unique case (req.op)
      ssmac_pkg::OP_BYTE_LANE_LOGICAL_RIGHT_SHIFT: begin
        for (int i = 0; i < 4; i++) begin
          res_nxt.data[8*i +: 8] = req.rt[8*i +: 8] >> cnt[2:0]; // RL1
        end
      end
      ssmac_pkg::OP_HALF_LANE_ARITH_RIGHT_SHIFT: begin
        for (int i = 0; i < 2; i++) begin
          h_ext = {req.rt[16*i+15], req.rt[16*i +: 16]};
          h_ext = 17'($signed(h_ext) >>> cnt[3:0]); // RL2
          res_nxt.data[16*i +: 16] = h_ext[15:0];
        end
      end
      ssmac_pkg::OP_HALF_LANE_ROUNDING_RIGHT_SHIFT: begin
        // a zero count discards nothing, so nothing is added
        h_rnd = (cnt[3:0] == 4'h0) ? 17'h0 : 17'(17'h1 << (cnt[3:0] - 4'h1)); // RL3 RL23
        for (int i = 0; i < 2; i++) begin
          h_ext = {req.rt[16*i+15], req.rt[16*i +: 16]} + h_rnd; // RL3
          h_ext = 17'($signed(h_ext) >>> cnt[3:0]); // RL2
          res_nxt.data[16*i +: 16] = h_ext[15:0];
        end
      end
      ssmac_pkg::OP_WORD_ROUNDING_RIGHT_SHIFT: begin
        w_rnd = (cnt == 5'h0) ? 33'h0 : 33'(33'h1 << (cnt - 5'h1)); // RL3 RL23
        w_ext = {req.rt[31], req.rt} + w_rnd;
        w_ext = 33'($signed(w_ext) >>> cnt); // RL4
        res_nxt.data = w_ext[31:0];
      end
      ssmac_pkg::OP_BYTE_BY_HALF_MULTIPLY_LEFT,
      ssmac_pkg::OP_BYTE_BY_HALF_MULTIPLY_RIGHT: begin
        for (int i = 0; i < 2; i++) begin
          if (req.op == ssmac_pkg::OP_BYTE_BY_HALF_MULTIPLY_LEFT) begin
            byte_a = req.rs[16+8*i +: 8]; // RL5
          end else begin
            byte_a = req.rs[8*i +: 8]; // RL5
          end
          p24 = {16'h0, byte_a} * {8'h0, req.rt[16*i +: 16]}; // RL5
          res_nxt.data[16*i +: 16] = (p24[23:16] != 8'h0) ? ssmac_pkg::U16_MAX
                                                          : p24[15:0]; // RL6
        end
      end
      ssmac_pkg::OP_Q15_ROUNDING_MULTIPLY: begin
        rnd_sum = p_high + ssmac_pkg::Q31_RND; // RL7
        res_nxt.data[31:16] = sat_high ? ssmac_pkg::Q15_MAX : rnd_sum[31:16]; // RL8
        rnd_sum = p_low + ssmac_pkg::Q31_RND; // RL7
        res_nxt.data[15:0] = sat_low ? ssmac_pkg::Q15_MAX : rnd_sum[31:16]; // RL8
      end
      ssmac_pkg::OP_Q15_EXPANDING_MULTIPLY_LEFT: begin
        res_nxt.data = p_high; // RL10
      end
      ssmac_pkg::OP_Q15_EXPANDING_MULTIPLY_RIGHT: begin
        res_nxt.data = p_low; // RL10
      end
      ssmac_pkg::OP_BYTE_DOT_ACCUMULATE: begin
        acc_nxt[sel] = acc_sel + {47'h0, bdot}; // RL11 RL22
      end
      ssmac_pkg::OP_BYTE_DOT_SUBTRACT: begin
        acc_nxt[sel] = acc_sel - {47'h0, bdot}; // RL12 RL22
      end
      ssmac_pkg::OP_Q15_DOT_ACCUMULATE: begin
        acc_nxt[sel] = acc_sel + sum64; // RL13
      end
      ssmac_pkg::OP_Q15_DOT_SUBTRACT: begin
        acc_nxt[sel] = acc_sel - sum64; // RL15
      end
      ssmac_pkg::OP_COMPLEX_REAL_PART_ACCUMULATE: begin
        acc_nxt[sel] = acc_sel + {{32{p_high[31]}}, p_high}
                               - {{32{p_low[31]}}, p_low}; // RL16
      end
      ssmac_pkg::OP_Q31_SAT_MAC: begin
        acc_nxt[sel] = sat64({acc_sel[63], acc_sel} + {q63[63], q63}); // RL18
      end
      ssmac_pkg::OP_Q31_SAT_MSUB: begin
        acc_nxt[sel] = sat64({acc_sel[63], acc_sel} - {q63[63], q63}); // RL19
      end
      ssmac_pkg::OP_SINGLE_LANE_MAC: begin
        acc_nxt[sel] = acc_sel + lane64; // RL20
      end
      ssmac_pkg::OP_SINGLE_LANE_MAC_Q31_CLAMP: begin
        acc_nxt[sel] = sat_q31(acc_sel + lane64); // RL21
      end
      ssmac_pkg::OP_MOVE_FROM_HIGH: begin
        res_nxt.data = acc_sel[63:32]; // RL22
      end
      ssmac_pkg::OP_MOVE_FROM_LOW: begin
        res_nxt.data = acc_sel[31:0]; // RL22
      end
      ssmac_pkg::OP_MOVE_TO_HIGH: begin
        acc_nxt[sel][63:32] = req.rs; // RL22
      end
      ssmac_pkg::OP_MOVE_TO_LOW: begin
        acc_nxt[sel][31:0] = req.rs; // RL22
      end
      default: begin
        res_nxt.data = '0;
      end
    endcase
    // an idle slot changes no accumulator and answers zero
    if (!req.valid) begin
      res_nxt.data = '0;
      acc_nxt = acc_r;
    end
  end

  // answer and accumulator registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      res_r <= '0;
      for (int i = 0; i < ACC_NUM; i++) begin
        acc_r[i] <= ssmac_pkg::ACC_RST;
      end
    end else begin
      res_r <= res_nxt;
      acc_r <= acc_nxt;
    end
  end

  // checks on the registered answer and accumulators
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence op_issued(ssmac_pkg::ssmac_op_t o);
    req.valid && req.op == o;
  endsequence

  byte_shift_a: assert property ( // RL1
    op_issued(ssmac_pkg::OP_BYTE_LANE_LOGICAL_RIGHT_SHIFT) |=> res_r.valid &&
      res_r.data[31:24] == ($past(req.rt[31:24]) >> $past(cnt[2:0])))
    else $error("byte lane shift result wrong");

  half_shift_a: assert property ( // RL2
    op_issued(ssmac_pkg::OP_HALF_LANE_ARITH_RIGHT_SHIFT) |=>
      res_r.data[31:16] == 16'($signed($past(req.rt[31:16])) >>> $past(cnt[3:0])))
    else $error("halfword arithmetic shift result wrong");

  round_one_a: assert property ( // RL3
    op_issued(ssmac_pkg::OP_HALF_LANE_ROUNDING_RIGHT_SHIFT) ##0 (cnt[3:0] == 4'h1) |=>
      res_r.data[15:0] == 16'(($signed({$past(req.rt[15]), $past(req.rt[15:0])})
                               + 17'sh1) >>> 1))
    else $error("rounding shift by one wrong");

  zero_round_a: assert property ( // RL23
    op_issued(ssmac_pkg::OP_HALF_LANE_ROUNDING_RIGHT_SHIFT) ##0 (cnt[3:0] == 4'h0) |=>
      res_r.data == $past(req.rt))
    else $error("zero count rounding shift changed data");

  word_zero_a: assert property ( // RL4
    op_issued(ssmac_pkg::OP_WORD_ROUNDING_RIGHT_SHIFT) ##0 (cnt == 5'h0) |=>
      res_r.data == $past(req.rt))
    else $error("zero count word shift changed data");

  byte_half_sat_a: assert property ( // RL6
    op_issued(ssmac_pkg::OP_BYTE_BY_HALF_MULTIPLY_LEFT) ##0 (req.rs[31:24] == 8'hff &&
      req.rt[31:16] == 16'hffff) |=> res_r.data[31:16] == ssmac_pkg::U16_MAX)
    else $error("byte by halfword lane did not saturate");

  q15_sat_a: assert property ( // RL8
    op_issued(ssmac_pkg::OP_Q15_ROUNDING_MULTIPLY) ##0 (req.rs[31:16] == 16'h8000 &&
      req.rt[31:16] == 16'h8000) |=> res_r.data[31:16] == ssmac_pkg::Q15_MAX)
    else $error("Q15 minus one product not clamped");

  expand_sat_a: assert property ( // RL10
    op_issued(ssmac_pkg::OP_Q15_EXPANDING_MULTIPLY_LEFT) ##0 (req.rs[31:16] == 16'h8000 &&
      req.rt[31:16] == 16'h8000) |=> res_r.data == ssmac_pkg::Q31_MAX)
    else $error("expanding minus one product not clamped");

  acc_keep_a: assert property ( // RL9
    req.valid && gpr_op |=> acc_r[1] == $past(acc_r[1]) &&
      acc_r[2] == $past(acc_r[2]) && acc_r[3] == $past(acc_r[3]))
    else $error("register-only operation changed an accumulator");

  lane_clamp_a: assert property ( // RL21
    op_issued(ssmac_pkg::OP_SINGLE_LANE_MAC_Q31_CLAMP) ##0 (req.accumulator_select == 2'h2) |=>
      acc_r[2][63:31] == {33{acc_r[2][63]}})
    else $error("clamping mac left the Q31 range");
endmodule
`default_nettype wire

// ---- dv/ssmac_issue_model.sv ----
// Purpose: pipeline side that presents decoded requests to the datapath
// Assumes: bench hands over one command per edge, changed just after the edge
// Notes: no request reaches the datapath while reset is held
`timescale 1ns/1ps
`default_nettype none
module ssmac_issue_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire ssmac_pkg::ssmac_req_t cmd,
  output var ssmac_pkg::ssmac_req_t req
);
  // command passes through, blanked while reset is low
  always_comb begin
    req = cmd;
    if (!rst_b) begin
      req = '0;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the packed shift and multiply datapath
// Assumes: answer one edge after the request, accumulators read back by moves
// Notes: every op is followed by one idle edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  ssmac_pkg::ssmac_req_t cmd = '0;
  ssmac_pkg::ssmac_req_t req;
  ssmac_pkg::ssmac_res_t res;
  logic [31:0] last = '0;
  logic last_v = 1'b0;
  int errors = 0;
  int comparisons = 0;

  ssmac_issue_model u_issue (.clk(clk), .rst_b(rst_b), .cmd(cmd), .req(req));
  ssmac_unit DUT (.clk(clk), .rst_b(rst_b), .req(req), .res(res));

  // 50 MHz core clock
  always #10 clk = ~clk;

  // issue one request, then capture the answer after it lands
  task automatic op(input ssmac_pkg::ssmac_op_t o, input logic [31:0] a, input logic [31:0] b,
    input logic [4:0] im, input logic uv, input logic lf, input logic [1:0] sl);
    @(posedge clk);
    cmd <= '{valid: 1'b1, op: o, rs: a, rt: b, imm: im, use_var: uv, left: lf,
      accumulator_select: sl};
    @(posedge clk);
    cmd <= '0;
    #1;
    last = res.data;
    last_v = res.valid;
  endtask

  // compare the last answer valid flag
  task automatic chkv(input logic exp);
    comparisons++;
    if (last_v !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, last_v, exp);
    end
  endtask

  // compare the last answer word
  task automatic chk(input logic [31:0] exp);
    comparisons++;
    if (last !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, last, exp);
    end
  endtask

  // load an accumulator pair through the move ops
  task automatic setacc(input logic [1:0] sl, input logic [31:0] hi, input logic [31:0] lo);
    op(ssmac_pkg::OP_MOVE_TO_HIGH, hi, '0, '0, 1'b0, 1'b0, sl);
    op(ssmac_pkg::OP_MOVE_TO_LOW, lo, '0, '0, 1'b0, 1'b0, sl);
  endtask

  // read an accumulator pair back and compare both halves
  task automatic chkacc(input logic [1:0] sl, input logic [31:0] hi, input logic [31:0] lo);
    op(ssmac_pkg::OP_MOVE_FROM_HIGH, '0, '0, '0, 1'b0, 1'b0, sl);
    chk(hi);
    op(ssmac_pkg::OP_MOVE_FROM_LOW, '0, '0, '0, 1'b0, 1'b0, sl);
    chk(lo);
  endtask

  // element shifts, immediate and register counts, rounding carries
  task automatic t_shifts;
    op(ssmac_pkg::OP_BYTE_LANE_LOGICAL_RIGHT_SHIFT, '0, 32'hf0f0f0f0, 5'h04, 1'b0, 1'b0, 2'h0);
    chk(32'h0f0f0f0f);
    chkv(1'b1);
    // an idle slot answers with nothing
    @(posedge clk);
    #1;
    last = res.data;
    last_v = res.valid;
    chk(32'h0);
    chkv(1'b0);
    op(ssmac_pkg::OP_BYTE_LANE_LOGICAL_RIGHT_SHIFT, 32'hf9, 32'h80ff0102, '0, 1'b1, 1'b0, 2'h0);
    chk(32'h407f0001);
    op(ssmac_pkg::OP_HALF_LANE_ARITH_RIGHT_SHIFT, '0, 32'h80007fff, 5'h04, 1'b0, 1'b0, 2'h0);
    chk(32'hf80007ff);
    op(ssmac_pkg::OP_HALF_LANE_ARITH_RIGHT_SHIFT, 32'h13, 32'h80080010, '0, 1'b1, 1'b0, 2'h0);
    chk(32'hf0010002);
    op(ssmac_pkg::OP_HALF_LANE_ROUNDING_RIGHT_SHIFT, '0, 32'h7ffffffd, 5'h01, 1'b0, 1'b0, 2'h0);
    chk(32'h4000ffff);
    op(ssmac_pkg::OP_HALF_LANE_ROUNDING_RIGHT_SHIFT, '0, 32'h12348765, 5'h00, 1'b0, 1'b0, 2'h0);
    chk(32'h12348765);
    op(ssmac_pkg::OP_WORD_ROUNDING_RIGHT_SHIFT, '0, 32'h40000000, 5'h1f, 1'b0, 1'b0, 2'h0);
    chk(32'h00000001);
    op(ssmac_pkg::OP_WORD_ROUNDING_RIGHT_SHIFT, 32'h21, 32'h00000005, '0, 1'b1, 1'b0, 2'h0);
    chk(32'h00000003);
    op(ssmac_pkg::OP_WORD_ROUNDING_RIGHT_SHIFT, '0, 32'h87654321, 5'h00, 1'b0, 1'b0, 2'h0);
    chk(32'h87654321);
  endtask

  // register-only multiplies, with accumulators one to three watched
  task automatic t_mults;
    for (int i = 0; i < 4; i++) begin
      chkacc(2'(i), 32'h0, 32'h0);
    end
    for (int i = 1; i < 4; i++) begin
      setacc(2'(i), 32'h11111111 * i, 32'h0f0f0f0f + i);
    end
    op(ssmac_pkg::OP_BYTE_BY_HALF_MULTIPLY_LEFT, 32'hff020000, 32'hffff0003, '0, 1'b0, 1'b0, 2'h1);
    chk(32'hffff0006);
    op(ssmac_pkg::OP_BYTE_BY_HALF_MULTIPLY_RIGHT, 32'h00000304, 32'h00101000, '0, 1'b0, 1'b0, 2'h2);
    chk(32'h00304000);
    op(ssmac_pkg::OP_Q15_ROUNDING_MULTIPLY, 32'h80000001, 32'h80004000, '0, 1'b0, 1'b0, 2'h3);
    chk(32'h7fff0001);
    op(ssmac_pkg::OP_Q15_EXPANDING_MULTIPLY_LEFT, 32'h80000000, 32'h80001234, '0, 1'b0, 1'b1, 2'h1);
    chk(32'h7fffffff);
    op(ssmac_pkg::OP_Q15_EXPANDING_MULTIPLY_RIGHT, 32'h00004000, 32'h0000c000, '0, 1'b0, 1'b0, 2'h2);
    chk(32'he0000000);
    for (int i = 1; i < 4; i++) begin
      chkacc(2'(i), 32'h11111111 * i, 32'h0f0f0f0f + i);
    end
  endtask

  // byte and Q15 dot products, complex real part
  task automatic t_dots;
    setacc(2'h1, 32'h0, 32'h0);
    op(ssmac_pkg::OP_BYTE_DOT_ACCUMULATE, 32'h00000203, 32'h00000203, '0, 1'b0, 1'b0, 2'h1);
    chk(32'h0);
    chkv(1'b1);
    chkacc(2'h1, 32'h0, 32'h0000000d);
    op(ssmac_pkg::OP_BYTE_DOT_ACCUMULATE, 32'hff010000, 32'hff020000, '0, 1'b0, 1'b1, 2'h1);
    chkacc(2'h1, 32'h0, 32'h0000fe10);
    op(ssmac_pkg::OP_BYTE_DOT_SUBTRACT, 32'hff000000, 32'hff000000, '0, 1'b0, 1'b1, 2'h1);
    op(ssmac_pkg::OP_BYTE_DOT_SUBTRACT, 32'h00000203, 32'h00000203, '0, 1'b0, 1'b0, 2'h1);
    op(ssmac_pkg::OP_BYTE_DOT_SUBTRACT, 32'h00000203, 32'h00000203, '0, 1'b0, 1'b0, 2'h1);
    chkacc(2'h1, 32'hffffffff, 32'hfffffff5);
    setacc(2'h2, 32'h0, 32'h0);
    op(ssmac_pkg::OP_Q15_DOT_ACCUMULATE, 32'h80004000, 32'h80004000, '0, 1'b0, 1'b0, 2'h2);
    chkacc(2'h2, 32'h0, 32'h9fffffff);
    op(ssmac_pkg::OP_Q15_DOT_SUBTRACT, 32'h80004000, 32'h80004000, '0, 1'b0, 1'b0, 2'h2);
    op(ssmac_pkg::OP_Q15_DOT_SUBTRACT, 32'h40004000, 32'h40004000, '0, 1'b0, 1'b0, 2'h2);
    chkacc(2'h2, 32'hffffffff, 32'hc0000000);
    setacc(2'h3, 32'h0, 32'h0);
    op(ssmac_pkg::OP_COMPLEX_REAL_PART_ACCUMULATE, 32'h40004000, 32'h4000c000, '0, 1'b0, 1'b0, 2'h3);
    chkacc(2'h3, 32'h0, 32'h40000000);
  endtask

  // Q31 mac and msub with accumulator clamps, single-lane macs
  task automatic t_q31;
    setacc(2'h0, 32'h7fffffff, 32'hffffffff);
    op(ssmac_pkg::OP_Q31_SAT_MAC, 32'h80000000, 32'h80000000, '0, 1'b0, 1'b0, 2'h0);
    chkacc(2'h0, 32'h7fffffff, 32'hffffffff);
    setacc(2'h0, 32'h0, 32'h0);
    op(ssmac_pkg::OP_Q31_SAT_MAC, 32'h40000000, 32'h40000000, '0, 1'b0, 1'b0, 2'h0);
    chkacc(2'h0, 32'h20000000, 32'h0);
    setacc(2'h0, 32'h80000000, 32'h0);
    op(ssmac_pkg::OP_Q31_SAT_MSUB, 32'h80000000, 32'h80000000, '0, 1'b0, 1'b0, 2'h0);
    chkacc(2'h0, 32'h80000000, 32'h0);
    setacc(2'h0, 32'h0, 32'h0);
    op(ssmac_pkg::OP_Q31_SAT_MSUB, 32'h40000000, 32'hc0000000, '0, 1'b0, 1'b0, 2'h0);
    chkacc(2'h0, 32'h20000000, 32'h0);
    setacc(2'h1, 32'h0, 32'h0);
    op(ssmac_pkg::OP_SINGLE_LANE_MAC, 32'h80000000, 32'h80000000, '0, 1'b0, 1'b1, 2'h1);
    op(ssmac_pkg::OP_SINGLE_LANE_MAC, 32'h00004000, 32'h00004000, '0, 1'b0, 1'b0, 2'h1);
    chkacc(2'h1, 32'h0, 32'h9fffffff);
    setacc(2'h2, 32'h0, 32'h7fffffff);
    op(ssmac_pkg::OP_SINGLE_LANE_MAC_Q31_CLAMP, 32'h00004000, 32'h00004000, '0, 1'b0, 1'b0, 2'h2);
    chkacc(2'h2, 32'h0, 32'h7fffffff);
    setacc(2'h2, 32'hffffffff, 32'h80000000);
    op(ssmac_pkg::OP_SINGLE_LANE_MAC_Q31_CLAMP, 32'h40000000, 32'hc0000000, '0, 1'b0, 1'b1, 2'h2);
    chkacc(2'h2, 32'hffffffff, 32'h80000000);
  endtask

  // verdict and end of run
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence after a six-cycle reset
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_mults;
    t_shifts;
    t_dots;
    t_q31;
    wrap_up;
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
